//--- hw/cfgmsg_params.svh
// Purpose: Constants for the configuration message target
// Assumes: 40 MHz tile clock
// Notes: Every field, token and timing figure lives here
`ifndef CFGMSG_PARAMS_SVH
`define CFGMSG_PARAMS_SVH

// ----------------------------------------
// Control tokens
// ----------------------------------------
`define CFGMSG_TOK_WRITE 8'hC0
`define CFGMSG_TOK_READ 8'hC1
`define CFGMSG_TOK_END 8'h01
`define CFGMSG_TOK_ACK 8'h03
`define CFGMSG_TOK_NACK 8'h04

// ----------------------------------------
// Field layout
// ----------------------------------------
`define CFGMSG_DEST_BYTES 2'd3
`define CFGMSG_REGN_BYTES 2'd2
`define CFGMSG_DATA_BYTES 2'd3
`define CFGMSG_NOREPLY 8'hFF
`define CFGMSG_PS_LOW 8'h0B
`define CFGMSG_WIDE_BYTES 3'd4
`define CFGMSG_NARROW_BYTES 3'd1

// ----------------------------------------
// Timing
// ----------------------------------------
`define CFGMSG_CLK_PS 25000
`define CFGMSG_RST_MIN_NS 5000
`define CFGMSG_INIT_MAX_NS 150000
`define CFGMSG_RST_MIN_CYC ((`CFGMSG_RST_MIN_NS * 1000 + `CFGMSG_CLK_PS - 1) / `CFGMSG_CLK_PS)
`define CFGMSG_INIT_MAX_CYC ((`CFGMSG_INIT_MAX_NS * 1000) / `CFGMSG_CLK_PS)

`endif

//--- hw/cfgmsg_pkg.sv
// Purpose: Types for the configuration message target
// Assumes: Nothing
// Notes: One-hot parser states
package cfgmsg_pkg;

    typedef enum logic [7:0] {
        ST_IDLE = 8'h01,
        ST_DEST = 8'h02,
        ST_REGN = 8'h04,
        ST_DATA = 8'h08,
        ST_TAIL = 8'h10,
        ST_ACCESS = 8'h20,
        ST_REPLY = 8'h40,
        ST_DRAIN = 8'h80
    } cfgmsg_state_t;

endpackage : cfgmsg_pkg

//--- hw/cfgmsg_fifo.sv
// Purpose: Small reply buffer between parser and channel-end
// Assumes: Synchronous active-high reset
// Notes: Flip-flop storage, honest full and empty
`timescale 1ns/100ps
`default_nettype none

module cfgmsg_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Fill side
    input wire logic wr_valid_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    output logic wr_ready_out,
    // Drain side
    output logic rd_valid_out,
    output logic [WIDTH-1:0] rd_data_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
        $error("cfgmsg_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [AW-1:0] wp_reg, wp_next, rp_reg, rp_next;
    logic [AW:0] cnt_reg, cnt_next;
    logic push, pop;

    assign wr_ready_out = (cnt_reg != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_reg != '0);
    assign rd_data_out = mem_reg[rp_reg];
    assign push = wr_valid_in && wr_ready_out;
    assign pop = rd_valid_out && rd_ready_in;

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_next[i] = mem_reg[i];
        end
        if (push) begin
            mem_next[wp_reg] = wr_data_in;
        end
        wp_next = push ? wp_reg + 1'b1 : wp_reg;
        rp_next = pop ? rp_reg + 1'b1 : rp_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            wp_reg <= '0;
            rp_reg <= '0;
            cnt_reg <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else begin
            wp_reg <= wp_next;
            rp_reg <= rp_next;
            cnt_reg <= cnt_next;
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

endmodule : cfgmsg_fifo

`default_nettype wire

//--- hw/cfgmsg_target.sv
// Purpose: Configuration register target driven by token messages
// Assumes: One clock at 40 MHz; token stream with valid and ready
// Notes: Register bank sits outside, reached through a request port
//
// Functional notes
// - Write with reply field low byte all ones gets no reply.
// - Multi-byte fields travel most significant byte first.
// - Status resource id is register number shifted eight, ORed 0x0B.
// - Write reply: tokens 3,1 on success, 4,1 on failure.
// - Read reply: token 3, 32-bit value, token 1; else 4,1.
// - Peripheral read reply carries data of the access width.
// - Reset held 5 us (target does not check it; bench holds reset 75 ns); booting starts within 150 us after release.
`timescale 1ns/100ps
`default_nettype none
`include "cfgmsg_params.svh"

module cfgmsg_target
    import cfgmsg_pkg::*;
#(
    parameter int BOOT_CYCLES = `CFGMSG_INIT_MAX_CYC,
    parameter int BUF_DEPTH = 2
) (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Request token stream
    input wire logic in_valid_in,
    input wire logic in_ctrl_in,
    input wire logic [7:0] in_byte_in,
    output logic in_ready_out,
    // Reply token stream
    output logic out_valid_out,
    output logic out_ctrl_out,
    output logic [7:0] out_byte_out,
    input wire logic out_ready_in,
    output logic [23:0] reply_dest_out,
    // Register bank port
    output logic reg_req_out,
    output logic reg_write_out,
    output logic [15:0] reg_num_out,
    output logic [31:0] reg_wdata_out,
    output logic [23:0] ps_resource_out,
    input wire logic reg_ack_in,
    input wire logic reg_err_in,
    input wire logic reg_narrow_in,
    input wire logic [31:0] reg_rdata_in,
    // Boot
    output logic boot_out
);
    localparam int BW = $clog2(BOOT_CYCLES + 1);

    if (BOOT_CYCLES < 1 || BOOT_CYCLES > `CFGMSG_INIT_MAX_CYC) begin : g_chk
        $error("cfgmsg_target: BOOT_CYCLES out of range");
    end

    // ----------------------------------------
    // Parser state
    // ----------------------------------------
    cfgmsg_state_t state_reg, state_next;
    logic [1:0] cnt_reg, cnt_next;
    logic [2:0] rcnt_reg, rcnt_next;
    logic [23:0] dest_reg, dest_next;
    logic [15:0] regn_reg, regn_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic write_reg, write_next, fail_reg, fail_next;
    logic dest_ok_reg, dest_ok_next, narrow_reg, narrow_next;
    logic take, is_end, suppress;
    logic [2:0] n_data;
    logic buf_valid, buf_ready, item_ctrl;
    logic [7:0] item_byte;
    cfgmsg_state_t reply_or_idle;

    assign in_ready_out = state_reg inside {ST_IDLE, ST_DEST, ST_REGN, ST_DATA, ST_TAIL,
                                            ST_DRAIN};
    assign take = in_valid_in && in_ready_out;
    assign is_end = in_ctrl_in && (in_byte_in == `CFGMSG_TOK_END);
    assign suppress = !dest_ok_reg || (write_reg && dest_reg[7:0] == `CFGMSG_NOREPLY);
    assign reply_or_idle = suppress ? ST_IDLE : ST_REPLY;
    assign n_data = (write_reg || fail_reg) ? 3'd0
                  : (narrow_reg ? `CFGMSG_NARROW_BYTES : `CFGMSG_WIDE_BYTES);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        rcnt_next = rcnt_reg;
        dest_next = dest_reg;
        regn_next = regn_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        write_next = write_reg;
        fail_next = fail_reg;
        dest_ok_next = dest_ok_reg;
        narrow_next = narrow_reg;
        case (state_reg)
            ST_IDLE: begin
                if (take && in_ctrl_in) begin
                    if (in_byte_in == `CFGMSG_TOK_WRITE || in_byte_in == `CFGMSG_TOK_READ) begin
                        write_next = (in_byte_in == `CFGMSG_TOK_WRITE);
                        fail_next = 1'b0;
                        dest_ok_next = 1'b0;
                        narrow_next = 1'b0;
                        cnt_next = 2'd0;
                        state_next = ST_DEST;
                    end
                end
            end
            ST_DEST: begin
                if (take && in_ctrl_in) begin
                    state_next = is_end ? ST_IDLE : ST_DRAIN;
                end else if (take) begin
                    dest_next = {dest_reg[15:0], in_byte_in};
                    cnt_next = cnt_reg + 2'd1;
                    if (cnt_reg == `CFGMSG_DEST_BYTES - 2'd1) begin
                        dest_ok_next = 1'b1;
                        cnt_next = 2'd0;
                        state_next = ST_REGN;
                    end
                end
            end
            ST_REGN, ST_DATA: begin
                if (take && in_ctrl_in) begin
                    fail_next = 1'b1;
                    state_next = is_end ? reply_or_idle : ST_DRAIN;
                end else if (take) begin
                    cnt_next = cnt_reg + 2'd1;
                    if (state_reg == ST_REGN) begin
                        regn_next = {regn_reg[7:0], in_byte_in};
                        if (cnt_reg == `CFGMSG_REGN_BYTES - 2'd1) begin
                            cnt_next = 2'd0;
                            state_next = write_reg ? ST_DATA : ST_TAIL;
                        end
                    end else begin
                        wdata_next = {wdata_reg[23:0], in_byte_in};
                        if (cnt_reg == `CFGMSG_DATA_BYTES) begin
                            cnt_next = 2'd0;
                            state_next = ST_TAIL;
                        end
                    end
                end
            end
            ST_TAIL: begin
                if (take && is_end) begin
                    state_next = ST_ACCESS;
                end else if (take) begin
                    fail_next = 1'b1;
                    state_next = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (take && is_end) begin
                    state_next = reply_or_idle;
                end
            end
            ST_ACCESS: begin
                if (reg_ack_in) begin
                    fail_next = reg_err_in;
                    rdata_next = reg_rdata_in;
                    narrow_next = reg_narrow_in;
                    state_next = (write_reg && dest_reg[7:0] == `CFGMSG_NOREPLY)
                               ? ST_IDLE : ST_REPLY;
                end
            end
            ST_REPLY: begin
                if (buf_ready) begin
                    rcnt_next = rcnt_reg + 3'd1;
                    if (rcnt_reg == n_data + 3'd1) begin
                        rcnt_next = 3'd0;
                        state_next = ST_IDLE;
                    end
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            state_reg <= ST_IDLE;
            cnt_reg <= 2'd0;
            rcnt_reg <= 3'd0;
            dest_reg <= 24'h00_0000;
            regn_reg <= 16'h0000;
            wdata_reg <= 32'h0000_0000;
            rdata_reg <= 32'h0000_0000;
            write_reg <= 1'b0;
            fail_reg <= 1'b0;
            dest_ok_reg <= 1'b0;
            narrow_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            rcnt_reg <= rcnt_next;
            dest_reg <= dest_next;
            regn_reg <= regn_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            write_reg <= write_next;
            fail_reg <= fail_next;
            dest_ok_reg <= dest_ok_next;
            narrow_reg <= narrow_next;
        end
    end

    // ----------------------------------------
    // Register port
    // ----------------------------------------
    assign reg_req_out = (state_reg == ST_ACCESS);
    assign reg_write_out = write_reg;
    assign reg_num_out = regn_reg;
    assign reg_wdata_out = wdata_reg;
    assign ps_resource_out = {regn_reg, `CFGMSG_PS_LOW};
    assign reply_dest_out = dest_reg;

    // ----------------------------------------
    // Reply items
    // ----------------------------------------
    always_comb begin
        item_ctrl = 1'b1;
        item_byte = `CFGMSG_TOK_END;
        if (rcnt_reg == 3'd0) begin
            item_byte = fail_reg ? `CFGMSG_TOK_NACK : `CFGMSG_TOK_ACK;
        end else if (rcnt_reg <= n_data) begin
            item_ctrl = 1'b0;
            if (narrow_reg) begin
                item_byte = rdata_reg[7:0];
            end else begin
                item_byte = rdata_reg[8*(4-rcnt_reg) +: 8];
            end
        end
    end

    assign buf_valid = (state_reg == ST_REPLY);

    cfgmsg_fifo #(.WIDTH(9), .DEPTH(BUF_DEPTH)) u_buf (
        .clock_in(clock_in),
        .srst_in(srst_in),
        .wr_valid_in(buf_valid),
        .wr_data_in({item_ctrl, item_byte}),
        .wr_ready_out(buf_ready),
        .rd_valid_out(out_valid_out),
        .rd_data_out({out_ctrl_out, out_byte_out}),
        .rd_ready_in(out_ready_in)
    );

    // ----------------------------------------
    // Boot delay
    // ----------------------------------------
    logic [BW-1:0] boot_cnt_reg, boot_cnt_next;
    logic boot_reg, boot_next;

    always_comb begin
        boot_cnt_next = boot_cnt_reg;
        boot_next = boot_reg;
        if (boot_cnt_reg == BW'(BOOT_CYCLES - 1)) begin
            boot_next = 1'b1;
        end else begin
            boot_cnt_next = boot_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            boot_cnt_reg <= '0;
            boot_reg <= 1'b0;
        end else begin
            boot_cnt_reg <= boot_cnt_next;
            boot_reg <= boot_next;
        end
    end

    assign boot_out = boot_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (srst_in);

    logic [BW:0] since_rel_reg;
    always_ff @(posedge clock_in) begin
        if (srst_in) begin
            since_rel_reg <= '0;
        end else if (since_rel_reg != '1) begin
            since_rel_reg <= since_rel_reg + 1'b1;
        end
    end

    sequence s_wr_hdr;
        state_reg == ST_IDLE && take && in_ctrl_in && in_byte_in == `CFGMSG_TOK_WRITE;
    endsequence
    sequence s_rd_hdr;
        state_reg == ST_IDLE && take && in_ctrl_in && in_byte_in == `CFGMSG_TOK_READ;
    endsequence

    write_header_a: assert property (s_wr_hdr |=> state_reg == ST_DEST && write_reg)
        else $error("write header not taken");
    read_header_a: assert property (s_rd_hdr |=> state_reg == ST_DEST && !write_reg)
        else $error("read header not taken");
    reply_suppress_a: assert property (state_reg == ST_ACCESS && reg_ack_in && write_reg
            && dest_reg[7:0] == 8'hFF |=> state_reg == ST_IDLE [*2])
        else $error("suppressed reply was sent");
    status_token_a: assert property (state_reg == ST_REPLY && rcnt_reg == 3'd0
            |-> item_ctrl && item_byte == (fail_reg ? 8'h04 : 8'h03))
        else $error("wrong status token");
    msb_first_a: assert property (state_reg == ST_REPLY && rcnt_reg == 3'd1 && !narrow_reg
            && n_data == 3'd4 |-> !item_ctrl && item_byte == rdata_reg[31:24])
        else $error("data not sent msb first");
    narrow_data_a: assert property (state_reg == ST_REPLY && narrow_reg && n_data != 3'd0
            && rcnt_reg == 3'd2 |-> item_ctrl && item_byte == 8'h01)
        else $error("narrow reply has wrong length");
    ps_resource_a: assert property ($changed(regn_reg) ##1 $stable(regn_reg)
            |-> ps_resource_out[7:0] == 8'h0B && ps_resource_out[23:8] == $past(regn_reg))
        else $error("status resource id wrong");
    boot_bound_a: assert property (since_rel_reg >= (BW+1)'(BOOT_CYCLES + 1) |-> boot_out)
        else $error("boot not started in time");
    req_hold_a: assert property (reg_req_out && !reg_ack_in |=> reg_req_out)
        else $error("register request dropped");

endmodule : cfgmsg_target

`default_nettype wire

//--- verif/cfgmsg_chanend_model.sv
// Purpose: Requesting channel-end, reply side: accepts and records reply tokens
// Assumes: Reply stream with valid and ready, one clock
// Notes: Slow mode opens ready for two cycles out of four
`timescale 1ns/100ps
`default_nettype none

module cfgmsg_chanend_model (
    // Clock and reset
    input wire logic clock_in,
    input wire logic srst_in,
    // Pace control
    input wire logic slow_in,
    // Reply token stream
    input wire logic valid_in,
    input wire logic ctrl_in,
    input wire logic [7:0] byte_in,
    output logic ready_out
);
    logic [8:0] rx_q[$];
    logic [1:0] phase_reg = 2'h0;

    // Ready moves only off the sampling edge
    always @(negedge clock_in) begin
        phase_reg <= phase_reg + 2'h1;
        ready_out <= slow_in ? phase_reg[1] : 1'b1;
    end

    // Tokens kept in arrival order, bytes as sent
    always @(posedge clock_in) begin
        if ($sampled(srst_in) === 1'b0 && $sampled(valid_in) === 1'b1
                && $sampled(ready_out) === 1'b1) begin
            rx_q.push_back({$sampled(ctrl_in), $sampled(byte_in)});
        end
    end
endmodule : cfgmsg_chanend_model

`default_nettype wire

//--- verif/config_register_message_access_bench.sv
// Purpose: Self-checking bench for the configuration message target
// Assumes: 40 MHz clock, inputs driven at the falling edge
// Notes: Bench sends requests and acts as register bank
`timescale 1ns/100ps
`default_nettype none
`include "cfgmsg_params.svh"

module config_register_message_access_bench
    import cfgmsg_pkg::*;
;
    localparam int BOOT = 20;
    logic clock_in = 1'b0;
    logic srst_in, in_valid_in, in_ctrl_in, in_ready_out;
    logic [7:0] in_byte_in, out_byte_out;
    logic out_valid_out, out_ctrl_out, out_ready_in, boot_out, slow;
    logic [23:0] reply_dest_out, ps_resource_out;
    logic reg_req_out, reg_write_out;
    logic reg_ack_in = 1'b0;
    logic reg_err_in = 1'b0;
    logic reg_narrow_in = 1'b0;
    logic [15:0] reg_num_out;
    logic [31:0] reg_wdata_out;
    logic [31:0] reg_rdata_in = 32'h0000_0000;
    logic bank_err, bank_narrow, cap_write;
    logic [31:0] bank_data, cap_wdata;
    logic [15:0] cap_num;
    logic [23:0] cap_ps;
    logic [8:0] exp_q[$];
    int acc_delay, err_count, samples_checked;
    int acc_count = 0;
    int wait_n = 0;

    always #12.5 clock_in = ~clock_in;

    cfgmsg_target #(.BOOT_CYCLES(BOOT), .BUF_DEPTH(2)) u_dut (
        .clock_in(clock_in), .srst_in(srst_in),
        .in_valid_in(in_valid_in), .in_ctrl_in(in_ctrl_in), .in_byte_in(in_byte_in),
        .in_ready_out(in_ready_out), .out_valid_out(out_valid_out),
        .out_ctrl_out(out_ctrl_out), .out_byte_out(out_byte_out),
        .out_ready_in(out_ready_in), .reply_dest_out(reply_dest_out),
        .reg_req_out(reg_req_out), .reg_write_out(reg_write_out),
        .reg_num_out(reg_num_out), .reg_wdata_out(reg_wdata_out),
        .ps_resource_out(ps_resource_out), .reg_ack_in(reg_ack_in),
        .reg_err_in(reg_err_in), .reg_narrow_in(reg_narrow_in),
        .reg_rdata_in(reg_rdata_in), .boot_out(boot_out)
    );

    cfgmsg_chanend_model u_req (
        .clock_in(clock_in), .srst_in(srst_in), .slow_in(slow),
        .valid_in(out_valid_out), .ctrl_in(out_ctrl_out), .byte_in(out_byte_out),
        .ready_out(out_ready_in)
    );

    // ----------------------------------------
    // Register bank responder
    // ----------------------------------------
    always @(negedge clock_in) begin
        reg_ack_in <= 1'b0;
        if (reg_req_out === 1'b1 && reg_ack_in !== 1'b1) begin
            if (wait_n >= acc_delay) begin
                reg_ack_in <= 1'b1;
                reg_err_in <= bank_err;
                reg_narrow_in <= bank_narrow;
                reg_rdata_in <= bank_data;
                cap_write = reg_write_out;
                cap_num = reg_num_out;
                cap_wdata = reg_wdata_out;
                cap_ps = ps_resource_out;
                acc_count++;
                wait_n = 0;
            end else begin
                wait_n++;
            end
        end else if (reg_ack_in !== 1'b1) begin
            reg_rdata_in <= ~reg_rdata_in;
            reg_err_in <= ~reg_err_in;
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic test_done;
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_tok(input logic [8:0] got, input logic [8:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t reply token got %h expected %h", $time, got, exp);
        end
    endtask : cmp_tok

    task automatic send_tok(input logic c, input logic [7:0] b);
        int n;
        n = 0;
        @(negedge clock_in);
        in_valid_in = 1'b1;
        in_ctrl_in = c;
        in_byte_in = b;
        #1;
        while (in_ready_out !== 1'b1 && n < 300) begin
            @(negedge clock_in);
            #1;
            n++;
        end
        @(posedge clock_in);
    endtask : send_tok

    task automatic send_msg(input logic wr, input logic [23:0] dest, input logic [15:0] rn,
                            input logic [31:0] d);
        send_tok(1'b1, wr ? `CFGMSG_TOK_WRITE : `CFGMSG_TOK_READ);
        for (int i = 2; i >= 0; i--) send_tok(1'b0, dest[i*8 +: 8]);
        for (int i = 1; i >= 0; i--) send_tok(1'b0, rn[i*8 +: 8]);
        if (wr) for (int i = 3; i >= 0; i--) send_tok(1'b0, d[i*8 +: 8]);
        send_tok(1'b1, `CFGMSG_TOK_END);
        @(negedge clock_in);
        in_valid_in = 1'b0;
        in_byte_in = ~in_byte_in;
    endtask : send_msg

    task automatic check_reply;
        int n;
        n = 0;
        #1;
        while ((in_ready_out !== 1'b1 || u_req.rx_q.size() < exp_q.size()) && n < 400) begin
            @(negedge clock_in);
            n++;
        end
        repeat (8) @(negedge clock_in);
        cmp_val(u_req.rx_q.size(), exp_q.size(), "reply length");
        foreach (exp_q[i]) if (i < u_req.rx_q.size()) cmp_tok(u_req.rx_q[i], exp_q[i]);
        u_req.rx_q.delete();
        exp_q.delete();
    endtask : check_reply

    task automatic set_bank(input logic e, input logic nar, input logic [31:0] d, input int dl);
        bank_err = e;
        bank_narrow = nar;
        bank_data = d;
        acc_delay = dl;
    endtask : set_bank

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset_boot;
        int n;
        n = 0;
        @(negedge clock_in);
        cmp_val({in_ready_out, out_valid_out, reg_req_out, boot_out}, 32'h0000_0008, "reset");
        srst_in = 1'b0;
        while (boot_out !== 1'b1 && n < 40) begin
            @(negedge clock_in);
            n++;
        end
        cmp_val(n >= BOOT - 1 && n <= BOOT + 1, 32'h0000_0001, "boot delay");
    endtask : t_reset_boot

    task automatic t_write_ok;
        slow = 1'b1;
        set_bank(1'b0, 1'b0, 32'h0000_0000, 3);
        send_msg(1'b1, 24'h12_3456, 16'hABCD, 32'h0102_0304);
        exp_q = '{{1'b1, `CFGMSG_TOK_ACK}, {1'b1, `CFGMSG_TOK_END}};
        check_reply();
        cmp_val(reply_dest_out, 32'h0012_3456, "reply dest");
        cmp_val(cap_write, 32'h0000_0001, "write flag");
        cmp_val(cap_num, 32'h0000_ABCD, "reg number");
        cmp_val(cap_wdata, 32'h0102_0304, "write data");
        cmp_val(cap_ps, {16'hABCD, `CFGMSG_PS_LOW}, "status id");
    endtask : t_write_ok

    task automatic t_write_fail_quiet;
        int base;
        slow = 1'b0;
        set_bank(1'b1, 1'b0, 32'h0000_0000, 0);
        send_msg(1'b1, 24'h00_0A30, 16'h0005, 32'hFFFF_0000);
        exp_q = '{{1'b1, `CFGMSG_TOK_NACK}, {1'b1, `CFGMSG_TOK_END}};
        check_reply();
        base = acc_count;
        set_bank(1'b0, 1'b0, 32'h0000_0000, 1);
        send_msg(1'b1, 24'h00_07FF, 16'h0102, 32'h8000_0001);
        check_reply();
        cmp_val(acc_count - base, 32'h0000_0001, "quiet access");
        cmp_val(cap_wdata, 32'h8000_0001, "quiet data");
    endtask : t_write_fail_quiet

    task automatic t_reads;
        slow = 1'b1;
        set_bank(1'b0, 1'b0, 32'hDEAD_BEEF, 2);
        send_msg(1'b0, 24'h34_56FF, 16'h0300, 32'h0000_0000);
        exp_q = '{9'h103, 9'h0DE, 9'h0AD, 9'h0BE, 9'h0EF, 9'h101};
        check_reply();
        cmp_val(cap_write, 32'h0000_0000, "read flag");
        cmp_val(cap_ps, 32'h0003_000B, "status id");
        set_bank(1'b0, 1'b1, 32'h1234_5678, 0);
        send_msg(1'b0, 24'h01_0204, 16'h0001, 32'h0000_0000);
        exp_q = '{9'h103, 9'h078, 9'h101};
        check_reply();
        slow = 1'b0;
        set_bank(1'b1, 1'b0, 32'h5555_AAAA, 4);
        send_msg(1'b0, 24'h01_0204, 16'h0010, 32'h0000_0000);
        exp_q = '{9'h104, 9'h101};
        check_reply();
    endtask : t_reads

    task automatic t_malformed;
        int base;
        base = acc_count;
        send_tok(1'b0, 8'h55);
        send_tok(1'b1, `CFGMSG_TOK_READ);
        for (int i = 0; i < 3; i++) send_tok(1'b0, 8'h20 + 8'(i));
        send_tok(1'b1, 8'h05);
        send_tok(1'b0, 8'h77);
        send_tok(1'b1, `CFGMSG_TOK_END);
        @(negedge clock_in);
        in_valid_in = 1'b0;
        exp_q = '{9'h104, 9'h101};
        check_reply();
        cmp_val(acc_count - base, 32'h0000_0000, "bad message access");
        cmp_val(reply_dest_out, 32'h0020_2122, "bad message dest");
    endtask : t_malformed

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        srst_in = 1'b1;
        in_valid_in = 1'b0;
        in_ctrl_in = 1'b0;
        in_byte_in = 8'h00;
        slow = 1'b0;
        set_bank(1'b0, 1'b0, 32'h0000_0000, 0);
        err_count = 0;
        samples_checked = 0;
        repeat (3) @(posedge clock_in);
        t_reset_boot();
        t_write_ok();
        t_write_fail_quiet();
        t_reads();
        t_malformed();
        test_done();
    end

    initial begin
        #125000;
        err_count++;
        test_done();
    end
endmodule : config_register_message_access_bench

`default_nettype wire
